// [core/vlc_top.sv]
// top: vref ladder control register, pin gating and ladder controls
// Function
// [RL1] range bit picks 24-step or quarter-offset 32-step
// [RL2] source bit picks external pins or supply
// [RL3] tap value selects one of sixteen levels
// [RL4] reset clears ladder power enable
// [RL5] reset clears pin output enable
// [RL6] reset clears range and tap bits
// [RL7] sleep wake leaves register unchanged
// [RL8] software should disable reference before sleep
// [RL9] pin driven only if direction input and enabled
// [RL10] independent of comparator configuration
// [RL11] power bit powers ladder on or down
// [RL12] output enable connects reference to shared pin
// [RL13] all eight bits readable, writes apply next clock
//
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/100ps
module vlc_top
    import vlc_pkg::*;
(
    // clock and reset
    input  wire logic       SYS_CLK_I,
    input  wire logic       RST_I,
    input  wire logic       CLK_EN_I,
    // register port
    input  wire logic [3:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    // port direction bit from the port block, async to us
    input  wire logic       PORT_F_DIRECTION_I,
    // ladder controls
    output logic            LADDER_POWER_ENABLE_O,
    output logic            LADDER_SOURCE_SELECT_O,
    output logic            LADDER_RANGE_SELECT_O,
    output logic      [3:0] LADDER_TAP_VALUE_O,
    output logic      [5:0] LADDER_LEVEL_NUMER_O,
    output logic      [5:0] LADDER_LEVEL_DENOM_O,
    // shared pin switch
    output logic            SHARED_REF_PIN_CONNECT_O
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic vlc_ctrl_t vlc_unpack(input logic [7:0] raw);
        vlc_ctrl_t c;
        c.ladder_power_enable   = raw[VLC_BIT_POWER];
        c.ref_pin_output_enable = raw[VLC_BIT_PINOE];
        c.ladder_range_select   = vlc_range_t'(raw[VLC_BIT_RANGE]);
        c.ladder_source_select  = vlc_source_t'(raw[VLC_BIT_SOURCE]);
        c.ladder_tap_value      = raw[VLC_TAP_MSB:0];
        return c;
    endfunction

    // ------------------------------------------------------------------
    // control register
    // ------------------------------------------------------------------
    logic [7:0] control_reg;
    logic [7:0] control_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       pin_connect_reg;
    logic       pin_connect_next;

    always_comb begin
        control_next = control_reg;
        rdata_next   = rdata_reg;
        // no sleep input: wake leaves contents alone by construction
        if (WR_I && ADDR_I == VLC_ADDR_CONTROL) begin
            control_next = WDATA_I;                                  // [RL13] [RL7]
        end
        if (RD_I) begin
            if (ADDR_I == VLC_ADDR_CONTROL) begin
                rdata_next = control_reg;                            // [RL13]
            end else if (ADDR_I == VLC_ADDR_STATUS) begin
                rdata_next = {7'h00, pin_connect_reg};
            end else begin
                rdata_next = 8'h00;
            end
        end else begin
            rdata_next = 8'h00;
        end
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            control_reg <= VLC_CONTROL_RST;                          // [RL4] [RL5] [RL6]
            rdata_reg   <= 8'h00;
        end else if (CLK_EN_I) begin
            control_reg <= control_next;
            rdata_reg   <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // direction bit synchroniser and pin gate
    // ------------------------------------------------------------------
    logic [2:0] dir_sync_reg;
    logic [2:0] dir_sync_next;
    logic       dir_input_reg;
    logic       dir_input_next;
    vlc_ctrl_t  ctrl;

    assign ctrl = vlc_unpack(control_reg);

    always_comb begin
        dir_sync_next  = {dir_sync_reg[1:0], PORT_F_DIRECTION_I};
        dir_input_next = dir_input_reg;
        // accept a change only once stages two and three agree
        if (dir_sync_reg[1] == dir_sync_reg[2]) begin
            dir_input_next = dir_sync_reg[2];
        end
        // comparator settings are not an input here
        pin_connect_next = ctrl.ref_pin_output_enable && dir_input_reg; // [RL9] [RL12] [RL10]
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            dir_sync_reg    <= 3'h0;
            dir_input_reg   <= 1'b0;
            pin_connect_reg <= 1'b0;
        end else if (CLK_EN_I) begin
            dir_sync_reg    <= dir_sync_next;
            dir_input_reg   <= dir_input_next;
            pin_connect_reg <= pin_connect_next;
        end
    end

    // ------------------------------------------------------------------
    // ladder level
    // ------------------------------------------------------------------
    vlc_level_t level;

    vlc_level_map i_vlc_level_map (
        .range_i (ctrl.ladder_range_select),
        .tap_i   (ctrl.ladder_tap_value),
        .level_o (level)
    );

    assign RDATA_O                  = rdata_reg;
    assign LADDER_POWER_ENABLE_O    = ctrl.ladder_power_enable;      // [RL11]
    assign LADDER_SOURCE_SELECT_O   = ctrl.ladder_source_select;     // [RL2]
    assign LADDER_RANGE_SELECT_O    = ctrl.ladder_range_select;      // [RL1]
    assign LADDER_TAP_VALUE_O       = ctrl.ladder_tap_value;         // [RL3]
    assign LADDER_LEVEL_NUMER_O     = level.numer;
    assign LADDER_LEVEL_DENOM_O     = level.denom;
    assign SHARED_REF_PIN_CONNECT_O = pin_connect_reg;

endmodule // vlc_top

// [core/vlc_pkg.sv]
// package: register map, field layout, reset values and carriers for the vref ladder control
package vlc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [3:0] VLC_ADDR_CONTROL = 4'h0;
    localparam logic [3:0] VLC_ADDR_STATUS  = 4'h1;
    localparam logic [7:0] VLC_CONTROL_RST  = 8'h00;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int VLC_BIT_POWER  = 7;
    localparam int VLC_BIT_PINOE  = 6;
    localparam int VLC_BIT_RANGE  = 5;
    localparam int VLC_BIT_SOURCE = 4;
    localparam int VLC_TAP_MSB    = 3;
    localparam int VLC_PIN_BIT    = 5;

    // ------------------------------------------------------------------
    // ladder arithmetic: level = (base + tap) / denom of the span
    // ------------------------------------------------------------------
    localparam logic [5:0] VLC_DENOM_LOW  = 6'h18;
    localparam logic [5:0] VLC_DENOM_HIGH = 6'h20;
    localparam logic [5:0] VLC_BASE_LOW   = 6'h00;
    localparam logic [5:0] VLC_BASE_HIGH  = 6'h08;

    // range and source encodings
    typedef enum logic {VLC_RANGE_HIGH = 1'b0, VLC_RANGE_LOW = 1'b1} vlc_range_t;
    typedef enum logic {VLC_SRC_SUPPLY = 1'b0, VLC_SRC_EXTPIN = 1'b1} vlc_source_t;

    // decoded control fields
    typedef struct packed {
        logic        ladder_power_enable;
        logic        ref_pin_output_enable;
        vlc_range_t  ladder_range_select;
        vlc_source_t ladder_source_select;
        logic [3:0]  ladder_tap_value;
    } vlc_ctrl_t;

    // tap fraction sent to the analog ladder
    typedef struct packed {
        logic [5:0] numer;
        logic [5:0] denom;
    } vlc_level_t;

endpackage

// [core/vlc_level_map.sv]
// leaf: maps range and tap value onto a ladder fraction
`timescale 1ns/100ps
module vlc_level_map
    import vlc_pkg::*;
(
    // ladder selection
    input  wire vlc_range_t range_i,
    input  wire logic [3:0] tap_i,
    // fraction of the source span
    output vlc_level_t      level_o
);

    always_comb begin
        if (range_i == VLC_RANGE_LOW) begin
            level_o.numer = VLC_BASE_LOW + {2'h0, tap_i};            // [RL1] [RL3]
            level_o.denom = VLC_DENOM_LOW;
        end else begin
            level_o.numer = VLC_BASE_HIGH + {2'h0, tap_i};           // [RL1] [RL3]
            level_o.denom = VLC_DENOM_HIGH;
        end
    end

endmodule // vlc_level_map

// [verification/vlc_top_monitor.sv]
// checker: port-level properties of the vref ladder control
`timescale 1ns/100ps
module vlc_top_monitor (
    // clock, reset, register port
    input wire logic       SYS_CLK_I,
    input wire logic       RST_I,
    input wire logic       CLK_EN_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    // pin and ladder
    input wire logic       PORT_F_DIRECTION_I,
    input wire logic       LADDER_POWER_ENABLE_O,
    input wire logic       LADDER_SOURCE_SELECT_O,
    input wire logic       LADDER_RANGE_SELECT_O,
    input wire logic [3:0] LADDER_TAP_VALUE_O,
    input wire logic [5:0] LADDER_LEVEL_NUMER_O,
    input wire logic [5:0] LADDER_LEVEL_DENOM_O,
    input wire logic       SHARED_REF_PIN_CONNECT_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (RST_I);
    logic       wr0;
    logic [7:0] ov;
    // bit6 has no output of its own, so it is masked out
    assign wr0 = WR_I && CLK_EN_I && ADDR_I == 4'h0;
    assign ov = {LADDER_POWER_ENABLE_O, 1'b0, LADDER_RANGE_SELECT_O, LADDER_SOURCE_SELECT_O,
                 LADDER_TAP_VALUE_O};
    property p_wf(logic [7:0] m);
        logic [7:0] d;
        (wr0, d = WDATA_I) |=> (ov & m) == (d & m);
    endproperty
    sequence s_oe_clr;
        wr0 && !WDATA_I[6] ##1 (CLK_EN_I && !WR_I)[*2];
    endsequence
    AST_POWER: assert property (p_wf(8'h80)) else $error("power bit not written");
    AST_RANGE: assert property (p_wf(8'h20)) else $error("range bit not written");
    AST_SOURCE: assert property (p_wf(8'h10)) else $error("source bit not written");
    AST_TAP: assert property (p_wf(8'h0F)) else $error("tap not written");
    AST_LEVEL_LO: assert property (LADDER_RANGE_SELECT_O |-> LADDER_LEVEL_NUMER_O ==
        {2'h0, LADDER_TAP_VALUE_O} && LADDER_LEVEL_DENOM_O == 6'h18) else $error("low level");
    AST_LEVEL_HI: assert property (!LADDER_RANGE_SELECT_O |-> LADDER_LEVEL_NUMER_O == 6'h08 +
        {2'h0, LADDER_TAP_VALUE_O} && LADDER_LEVEL_DENOM_O == 6'h20) else $error("high level");
    AST_HOLD: assert property (!wr0 |=> $stable(ov)) else $error("controls moved");
    AST_READ: assert property (RD_I && CLK_EN_I && ADDR_I == 4'h0 |=>
        (RDATA_O & 8'hBF) == $past(ov)) else $error("readback wrong");
    AST_PIN_OFF: assert property ((CLK_EN_I && !PORT_F_DIRECTION_I)[*6] |->
        !SHARED_REF_PIN_CONNECT_O) else $error("pin on while output");
    AST_OE_OFF: assert property (s_oe_clr |-> !SHARED_REF_PIN_CONNECT_O)
        else $error("pin on after disable");
endmodule // vlc_top_monitor
bind vlc_top vlc_top_monitor i_vlc_top_monitor (.*);

// [verification/vlc_top_bench.sv]
// bench: register model compared with the vref ladder control
`timescale 1ns/100ps
module vlc_top_bench;
    logic clk = 0, rst = 1, en = 1, wr = 0, rd = 0, dir = 0, pw, ss, rs, sh;
    logic [3:0] a = 4'h0, tp;
    logic [7:0] wd = 8'h00, rdat, m = 8'h00;
    logic [5:0] nu, de;
    int miscompares = 0, samples_checked = 0, seed = 45, i;
    always #12.5 clk = ~clk;
    vlc_top i_vlc_top (.SYS_CLK_I(clk), .RST_I(rst), .CLK_EN_I(en), .ADDR_I(a), .WDATA_I(wd),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .PORT_F_DIRECTION_I(dir),
        .LADDER_POWER_ENABLE_O(pw), .LADDER_SOURCE_SELECT_O(ss), .LADDER_RANGE_SELECT_O(rs),
        .LADDER_TAP_VALUE_O(tp), .LADDER_LEVEL_NUMER_O(nu), .LADDER_LEVEL_DENOM_O(de),
        .SHARED_REF_PIN_CONNECT_O(sh));
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task chk(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task chk_out;
        chk({1'b0, pw, rs, ss, tp}, {1'b0, m[7], m[5:0]});
        chk({2'h0, nu}, m[5] ? {4'h0, m[3:0]} : 8'h08 + m[3:0]);
        chk({2'h0, de}, m[5] ? 8'h18 : 8'h20);
    endtask
    task wrt(input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk);
        wr <= 1; a <= ad; wd <= d;
        @(posedge clk);
        wr <= 0;
        if (ad == 4'h0 && en) m = d;
        #1;
    endtask
    task rdc(input logic [3:0] ad, input logic [7:0] e);
        @(posedge clk);
        rd <= 1; a <= ad;
        @(posedge clk);
        rd <= 0;
        #1 chk(rdat, e);
    endtask
    task end_sim;
        $display("compared %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        end_sim;
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        #1 chk_out;
        rdc(4'h0, 8'h00);
        $display("reset test done");
        for (i = 0; i < 40; i++) begin
            wrt(4'h0, i < 2 ? (i ? 8'hFF : 8'hC0) : 8'($random(seed)));
            chk_out;
            rdc(4'h0, m);
        end
        wrt(4'h2, 8'h55);
        chk_out;
        rdc(4'h2, 8'h00);
        $display("register test done");
        dir <= 1;
        wrt(4'h0, 8'h40);
        repeat (6) @(posedge clk);
        #1 chk({7'h0, sh}, 8'h01);
        rdc(4'h1, 8'h01);
        dir <= 0;
        repeat (6) @(posedge clk);
        #1 chk({7'h0, sh}, 8'h00);
        dir <= 1;
        repeat (6) @(posedge clk);
        wrt(4'h0, 8'h00);
        @(posedge clk);
        #1 chk({7'h0, sh}, 8'h00);
        $display("pin test done");
        // a frozen clock enable stands in for sleep: nothing may move
        wrt(4'h0, 8'h3F);
        chk_out;
        en <= 0;
        wrt(4'h0, 8'hAA);
        chk_out;
        en <= 1;
        wrt(4'h0, 8'hFF);
        rst <= 1;
        @(posedge clk);
        rst <= 0;
        m = 8'h00;
        #1 chk_out;
        rdc(4'h0, 8'h00);
        $display("retention test done");
        end_sim;
    end
endmodule // vlc_top_bench
